// [can_rx_irq_defines.svh]
`ifndef CAN_RX_IRQ_DEFINES_SVH
`define CAN_RX_IRQ_DEFINES_SVH

// register offsets on the local register port
`define ADDR_FLAG      8'h00
`define ADDR_ENABLE    8'h01

// field positions, shared by flag and enable registers
`define BIT_WAKEUP     7
`define BIT_STATUS     6
`define RX_SENS_HI     5
`define RX_SENS_LO     4
`define TX_SENS_HI     3
`define TX_SENS_LO     2
`define BIT_OVERRUN    1
`define BIT_RXFULL     0

// reset values
`define ENABLE_RESET   8'h00
`define FLAG_RESET     1'b0
`define STATE_RESET    2'h0

// enable bits that survive initialization mode
`define SENS_MASK      8'h3C

// error counter thresholds
`define WARN_LIMIT     9'h060
`define ERR_LIMIT      9'h07F
`define BUSOFF_LIMIT   9'h0FF

`endif

// [can_rx_irq_pkg.sv]
package can_rx_irq_pkg;

   // hardware encoding of the bus states is fixed, not gray
   typedef enum logic [1:0] {
      BUS_OK   = 2'h0,
      BUS_WARN = 2'h1,
      BUS_ERR  = 2'h2,
      BUS_OFF  = 2'h3
   } bus_state_type;

   typedef enum logic [1:0] {
      SENS_NONE   = 2'h0,
      SENS_BUSOFF = 2'h1,
      SENS_ERR    = 2'h2,
      SENS_ALL    = 2'h3
   } sensitivity_type;

endpackage : can_rx_irq_pkg

// [err_state_encode.sv]
`timescale 1ns/1ps
`include "can_rx_irq_defines.svh"

module err_state_encode
   import can_rx_irq_pkg::*;
#(
   parameter int CNT_W = 9
) (
   // counter and bus-off indication
   input  wire logic [CNT_W-1:0] err_count,
   input  wire logic             bus_off,
   // encoded state
   output bus_state_type         state
);

   always_comb begin
      if (bus_off) begin
         state = BUS_OFF;
      end else if (err_count <= CNT_W'(`WARN_LIMIT)) begin
         state = BUS_OK;
      end else if (err_count <= CNT_W'(`ERR_LIMIT)) begin
         state = BUS_WARN;
      end else begin
         state = BUS_ERR;
      end
   end

endmodule : err_state_encode

// [state_change_filter.sv]
`timescale 1ns/1ps

module state_change_filter
   import can_rx_irq_pkg::*;
(
   // stored and present state
   input  bus_state_type   old_state,
   input  bus_state_type   new_state,
   // sensitivity selection
   input  sensitivity_type sens,
   // change counts for the status-change flag
   output logic            hit
);

   always_comb begin
      case (sens)
         SENS_NONE:   hit = 1'b0;
         SENS_BUSOFF: hit = (old_state == BUS_OFF) != (new_state == BUS_OFF);
         SENS_ERR:    hit = (old_state >= BUS_ERR) != (new_state >= BUS_ERR);
         SENS_ALL:    hit = old_state != new_state;
         default:     hit = 1'b0;
      endcase
   end

endmodule : state_change_filter

// [can_receive_irq_enable.sv]
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "can_rx_irq_defines.svh"

module can_receive_irq_enable
   import can_rx_irq_pkg::*;
(
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       reset,
   // register port
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_write,
   input  wire logic       reg_read,
   output logic      [7:0] reg_rdata,
   // initialization handshake
   input  wire logic       init_mode_request,
   input  wire logic       init_mode_ack,
   // events from the controller core
   input  wire logic       wakeup_event,
   input  wire logic       overrun_event,
   input  wire logic       rx_full_event,
   // error counters
   input  wire logic [8:0] rx_error_count,
   input  wire logic [8:0] tx_error_count,
   // interrupt requests
   output logic            wakeup_irq,
   output logic            error_irq,
   output logic            rx_irq,
   output logic            irq
);

   logic [7:0]      receive_irq_enable;
   logic [7:0]      next_receive_irq_enable;
   logic            wakeup_flag;
   logic            next_wakeup_flag;
   logic            status_change_flag;
   logic            next_status_change_flag;
   logic            overrun_flag;
   logic            next_overrun_flag;
   logic            rx_full_flag;
   logic            next_rx_full_flag;
   bus_state_type   rx_bus_state;
   bus_state_type   next_rx_bus_state;
   bus_state_type   tx_bus_state;
   bus_state_type   next_tx_bus_state;
   logic [7:0]      next_reg_rdata;
   logic            next_wakeup_irq;
   logic            next_error_irq;
   logic            next_rx_irq;
   logic            next_irq;

   logic            init_active;
   logic            write_allowed;
   logic [7:0]      flag_clear;
   logic [7:0]      flag_view;
   bus_state_type   rx_error_state;
   bus_state_type   tx_error_state;
   logic            tx_bus_off;
   logic            rx_hit;
   logic            tx_hit;
   logic            state_moved;

   assign init_active   = init_mode_request & init_mode_ack;
   assign write_allowed = ~init_mode_request & ~init_mode_ack;
   assign tx_bus_off    = tx_error_count > `BUSOFF_LIMIT;

   // bus-off of the transmitter also forces the receiver code to bus-off
   err_state_encode #(
      .CNT_W     (9)
   ) u_rx_encode (
      .err_count (rx_error_count),
      .bus_off   (tx_bus_off),
      .state     (rx_error_state)
   );

   err_state_encode #(
      .CNT_W     (9)
   ) u_tx_encode (
      .err_count (tx_error_count),
      .bus_off   (tx_bus_off),
      .state     (tx_error_state)
   );

   state_change_filter u_rx_filter (
      .old_state (rx_bus_state),
      .new_state (rx_error_state),
      .sens      (sensitivity_type'(
                  receive_irq_enable[`RX_SENS_HI:`RX_SENS_LO])),
      .hit       (rx_hit)
   );

   state_change_filter u_tx_filter (
      .old_state (tx_bus_state),
      .new_state (tx_error_state),
      .sens      (sensitivity_type'(
                  receive_irq_enable[`TX_SENS_HI:`TX_SENS_LO])),
      .hit       (tx_hit)
   );

   // enable register
   always_comb begin
      next_receive_irq_enable = receive_irq_enable;
      if (init_active) begin
         // sensitivity fields survive, all other enables drop
         next_receive_irq_enable = receive_irq_enable & `SENS_MASK;
      end else if (reg_write && reg_addr == `ADDR_ENABLE && write_allowed) begin
         next_receive_irq_enable = reg_wdata;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         receive_irq_enable <= `ENABLE_RESET;
      end else begin
         receive_irq_enable <= next_receive_irq_enable;
      end
   end

   // flags and stored bus states; a set in the clear cycle wins, except the status flag, which clears and is set one cycle later
   always_comb begin
      flag_clear = (reg_write && reg_addr == `ADDR_FLAG) ? reg_wdata : 8'h00;
      state_moved = (rx_error_state != rx_bus_state) ||
                    (tx_error_state != tx_bus_state);
      next_rx_bus_state = rx_bus_state;
      next_tx_bus_state = tx_bus_state;
      next_status_change_flag = status_change_flag &
                                ~flag_clear[`BIT_STATUS];
      // frozen while a change is pending, so software sees the cause
      if (!status_change_flag && state_moved) begin
         next_rx_bus_state = rx_error_state;
         next_tx_bus_state = tx_error_state;
         if (rx_hit || tx_hit) begin
            next_status_change_flag = 1'b1;
         end
      end
      next_wakeup_flag  = wakeup_event |
                          (wakeup_flag & ~flag_clear[`BIT_WAKEUP]);
      next_overrun_flag = overrun_event |
                          (overrun_flag & ~flag_clear[`BIT_OVERRUN]);
      next_rx_full_flag = rx_full_event |
                          (rx_full_flag & ~flag_clear[`BIT_RXFULL]);
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         wakeup_flag        <= `FLAG_RESET;
         status_change_flag <= `FLAG_RESET;
         overrun_flag       <= `FLAG_RESET;
         rx_full_flag       <= `FLAG_RESET;
         rx_bus_state       <= bus_state_type'(`STATE_RESET);
         tx_bus_state       <= bus_state_type'(`STATE_RESET);
      end else begin
         wakeup_flag        <= next_wakeup_flag;
         status_change_flag <= next_status_change_flag;
         overrun_flag       <= next_overrun_flag;
         rx_full_flag       <= next_rx_full_flag;
         rx_bus_state       <= next_rx_bus_state;
         tx_bus_state       <= next_tx_bus_state;
      end
   end

   // read data and interrupt requests
   always_comb begin
      flag_view = {wakeup_flag, status_change_flag, rx_bus_state,
                   tx_bus_state, overrun_flag, rx_full_flag};
      case (reg_addr)
         `ADDR_FLAG:   next_reg_rdata = flag_view;
         `ADDR_ENABLE: next_reg_rdata = receive_irq_enable;
         default:      next_reg_rdata = 8'h00;
      endcase
      if (!reg_read) begin
         next_reg_rdata = 8'h00;
      end
      next_wakeup_irq = wakeup_flag &
                        receive_irq_enable[`BIT_WAKEUP];
      next_error_irq  = (status_change_flag &
                         receive_irq_enable[`BIT_STATUS]) |
                        (overrun_flag &
                         receive_irq_enable[`BIT_OVERRUN]);
      next_rx_irq     = rx_full_flag &
                        receive_irq_enable[`BIT_RXFULL];
      next_irq        = next_wakeup_irq | next_error_irq | next_rx_irq;
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         reg_rdata  <= 8'h00;
         wakeup_irq <= 1'b0;
         error_irq  <= 1'b0;
         rx_irq     <= 1'b0;
         irq        <= 1'b0;
      end else begin
         reg_rdata  <= next_reg_rdata;
         wakeup_irq <= next_wakeup_irq;
         error_irq  <= next_error_irq;
         rx_irq     <= next_rx_irq;
         irq        <= next_irq;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   sequence s_wake_armed;
      wakeup_event ##1 receive_irq_enable[`BIT_WAKEUP];
   endsequence

   sequence s_overrun_armed;
      overrun_event ##1 receive_irq_enable[`BIT_OVERRUN];
   endsequence

   sequence s_rxfull_armed;
      rx_full_event ##1 receive_irq_enable[`BIT_RXFULL];
   endsequence

   property p_init_hold;
      init_active |=> (receive_irq_enable & ~`SENS_MASK) == 8'h00;
   endproperty
   a_init_hold: assert property (p_init_hold)
      else $error("enable not reset in init mode");

   property p_write_taken;
      (reg_write && reg_addr == `ADDR_ENABLE && write_allowed)
         |=> receive_irq_enable == $past(reg_wdata);
   endproperty
   a_write_taken: assert property (p_write_taken)
      else $error("enable write lost");

   property p_write_blocked;
      (reg_write && reg_addr == `ADDR_ENABLE && !write_allowed &&
       !init_active) |=> $stable(receive_irq_enable);
   endproperty
   a_write_blocked: assert property (p_write_blocked)
      else $error("enable written during init handshake");

   property p_read_back;
      (reg_read && reg_addr == `ADDR_ENABLE)
         |=> reg_rdata == $past(receive_irq_enable);
   endproperty
   a_read_back: assert property (p_read_back)
      else $error("enable read back wrong");

   property p_sens_keep;
      init_active |=> receive_irq_enable[5:2] == $past(receive_irq_enable[5:2]);
   endproperty
   a_sens_keep: assert property (p_sens_keep)
      else $error("sensitivity lost in init mode");

   property p_wake_irq;
      s_wake_armed |=> wakeup_irq;
   endproperty
   a_wake_irq: assert property (p_wake_irq)
      else $error("wake-up request missing");

   property p_status_irq;
      (status_change_flag && receive_irq_enable[`BIT_STATUS]) |=> error_irq;
   endproperty
   a_status_irq: assert property (p_status_irq)
      else $error("status change request missing");

   property p_no_sens;
      (receive_irq_enable[5:2] == 4'h0 && !status_change_flag)
         |=> !status_change_flag;
   endproperty
   a_no_sens: assert property (p_no_sens)
      else $error("status change with sensitivity off");

   property p_state_freeze;
      status_change_flag |=> $stable(rx_bus_state) && $stable(tx_bus_state);
   endproperty
   a_state_freeze: assert property (p_state_freeze)
      else $error("state bits moved while change pending");

   property p_overrun_irq;
      s_overrun_armed |=> error_irq;
   endproperty
   a_overrun_irq: assert property (p_overrun_irq)
      else $error("overrun request missing");

   property p_rxfull_irq;
      s_rxfull_armed |=> rx_irq;
   endproperty
   a_rxfull_irq: assert property (p_rxfull_irq)
      else $error("receive request missing");

   property p_encode_ok;
      (!status_change_flag && rx_error_count <= `WARN_LIMIT && !tx_bus_off)
         |=> rx_bus_state == BUS_OK;
   endproperty
   a_encode_ok: assert property (p_encode_ok)
      else $error("receive state code wrong");

   property p_irq_or;
      irq == (wakeup_irq || error_irq || rx_irq);
   endproperty
   a_irq_or: assert property (p_irq_or)
      else $error("combined request mismatch");

endmodule : can_receive_irq_enable

// [can_host_model.sv]
`timescale 1ns/1ps

// software side of the register port: one bus cycle per call
module can_host_model (
   // clock
   input  wire logic       sys_clk,
   // register port
   output logic      [7:0] reg_addr,
   output logic      [7:0] reg_wdata,
   output logic            reg_write,
   output logic            reg_read,
   input  wire logic [7:0] reg_rdata
);
   initial begin
      reg_addr  = 8'h00;
      reg_wdata = 8'h00;
      reg_write = 1'b0;
      reg_read  = 1'b0;
   end

   // released lines show the inverse so a stale value never looks valid
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge sys_clk);
      reg_write <= 1'b0;
      reg_addr  <= ~a;
      reg_wdata <= ~d;
      // one idle edge, so a following call never reassigns in this step
      @(posedge sys_clk);
   endtask : write_reg

   task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge sys_clk);
      reg_read <= 1'b0;
      reg_addr <= ~a;
      // read data stand for exactly this cycle; take them at its closing edge
      @(posedge sys_clk);
      d = reg_rdata;
   endtask : read_reg
endmodule : can_host_model

// [can_receive_irq_enable_tb.sv]
`timescale 1ns/1ps

module can_receive_irq_enable_tb;
   import can_rx_irq_pkg::*;
   logic       sys_clk;
   logic       reset;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic       reg_write;
   logic       reg_read;
   logic [7:0] reg_rdata;
   logic       init_req;
   logic       init_ack;
   logic [2:0] ev;
   logic [8:0] rx_cnt;
   logic [8:0] tx_cnt;
   logic       wakeup_irq;
   logic       error_irq;
   logic       rx_irq;
   logic       irq;
   logic [7:0] irqs;
   int         error_cnt;
   int         check_count;

   assign irqs = {4'h0, wakeup_irq, error_irq, rx_irq, irq};

   can_host_model host (
      .sys_clk  (sys_clk),
      .reg_addr (reg_addr),
      .reg_wdata(reg_wdata),
      .reg_write(reg_write),
      .reg_read (reg_read),
      .reg_rdata(reg_rdata)
   );

   can_receive_irq_enable dut (
      .sys_clk          (sys_clk),
      .reset            (reset),
      .reg_addr         (reg_addr),
      .reg_wdata        (reg_wdata),
      .reg_write        (reg_write),
      .reg_read         (reg_read),
      .reg_rdata        (reg_rdata),
      .init_mode_request(init_req),
      .init_mode_ack    (init_ack),
      .wakeup_event     (ev[2]),
      .overrun_event    (ev[1]),
      .rx_full_event    (ev[0]),
      .rx_error_count   (rx_cnt),
      .tx_error_count   (tx_cnt),
      .wakeup_irq       (wakeup_irq),
      .error_irq        (error_irq),
      .rx_irq           (rx_irq),
      .irq              (irq)
   );

   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   task automatic complete_run;
      if (error_cnt == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : complete_run

   task automatic check(input string name, input logic [7:0] exp,
                        input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask : check

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : wait_cyc

   task automatic rd_check(input string name, input logic [7:0] a,
                           input logic [7:0] exp);
      logic [7:0] d;
      host.read_reg(a, d);
      check(name, exp, d);
   endtask : rd_check

   task automatic state_step(input logic [8:0] rc, input logic [8:0] tc,
                             input logic [7:0] exp_flags);
      rx_cnt <= rc;
      tx_cnt <= tc;
      wait_cyc(4);
      rd_check("flags", 8'h00, exp_flags);
      check("error_irq", {7'h00, exp_flags[6]}, {7'h00, error_irq});
   endtask : state_step

   task automatic clear_and_zero;
      host.write_reg(8'h00, 8'h40);
      rx_cnt <= 9'h000;
      tx_cnt <= 9'h000;
      wait_cyc(4);
      host.write_reg(8'h00, 8'h40);
      wait_cyc(4);
   endtask : clear_and_zero

   // wake-up, overrun, receive-full: flag bit and the requests they drive
   logic [7:0] ev_bit [3] = '{8'h80, 8'h02, 8'h01};
   logic [7:0] ev_irq [3] = '{8'h09, 8'h05, 8'h03};

   initial begin
      logic [1:0] sens;
      logic [7:0] exp_irq;
      error_cnt   = 0;
      check_count = 0;
      reset       = 1'b1;
      init_req    = 1'b0;
      init_ack    = 1'b0;
      ev          = 3'h0;
      rx_cnt      = 9'h000;
      tx_cnt      = 9'h000;
      wait_cyc(5);
      reset <= 1'b0;
      @(posedge sys_clk);
      rd_check("enable", 8'h01, 8'h00);
      rd_check("flags", 8'h00, 8'h00);
      check("irqs", 8'h00, irqs);
      host.write_reg(8'h01, 8'hFF);
      rd_check("enable", 8'h01, 8'hFF);
      @(posedge sys_clk);
      check("rdata_idle", 8'h00, reg_rdata);
      host.write_reg(8'h05, 8'h00);
      rd_check("unmapped", 8'h05, 8'h00);
      rd_check("enable", 8'h01, 8'hFF);
      // request alone: neither held nor writable
      init_req <= 1'b1;
      host.write_reg(8'h01, 8'h00);
      rd_check("enable", 8'h01, 8'hFF);
      init_ack <= 1'b1;
      wait_cyc(2);
      rd_check("enable", 8'h01, 8'h3C);
      host.write_reg(8'h01, 8'hC3);
      rd_check("enable", 8'h01, 8'h3C);
      init_req <= 1'b0;
      host.write_reg(8'h01, 8'h00);
      rd_check("enable", 8'h01, 8'h3C);
      init_ack <= 1'b0;
      @(posedge sys_clk);
      host.write_reg(8'h01, 8'h5A);
      rd_check("enable", 8'h01, 8'h5A);
      // wake-up goes first, each event with its enable clear before set; the core reports only qualified wake-ups
      for (int e = 0; e < 3; e++) begin
         for (int en = 0; en < 2; en++) begin
            host.write_reg(8'h01, (en == 1) ? ev_bit[e] : 8'h00);
            ev[2-e] <= 1'b1;
            @(posedge sys_clk);
            ev[2-e] <= 1'b0;
            wait_cyc(3);
            rd_check("flags", 8'h00, ev_bit[e]);
            exp_irq = (en == 1) ? ev_irq[e] : 8'h00;
            check("irqs", exp_irq, irqs);
            host.write_reg(8'h00, ev_bit[e]);
            wait_cyc(3);
            check("irqs", 8'h00, irqs);
         end
      end
      for (int s = 0; s < 4; s++) begin
         sens = s[1:0];
         host.write_reg(8'h01, {2'b01, sens, 4'h0});
         state_step(9'h060, 9'h000, 8'h00);
         state_step(9'h061, 9'h000, {1'b0, sens == 2'h3, 6'h10});
         clear_and_zero;
         state_step(9'h080, 9'h000, {1'b0, sens[1], 6'h20});
         clear_and_zero;
         host.write_reg(8'h01, {4'h4, sens, 2'b00});
         state_step(9'h000, 9'h100, {1'b0, sens != 2'h0, 6'h3C});
         clear_and_zero;
         state_step(9'h000, 9'h0FF, {1'b0, sens[1], 6'h08});
         clear_and_zero;
      end
      // a pending change freezes the state bits until software clears it
      host.write_reg(8'h01, 8'h70);
      state_step(9'h061, 9'h000, 8'h50);
      state_step(9'h080, 9'h000, 8'h50);
      host.write_reg(8'h00, 8'h40);
      wait_cyc(4);
      rd_check("flags", 8'h00, 8'h60);
      clear_and_zero;
      // status change with its enable clear raises no request
      host.write_reg(8'h01, 8'h30);
      rx_cnt <= 9'h061;
      wait_cyc(4);
      check("error_irq", 8'h00, {7'h00, error_irq});
      rd_check("flags", 8'h00, 8'h50);
      clear_and_zero;
      complete_run();
   end

   initial begin
      wait_cyc(5000);
      error_cnt++;
      complete_run();
   end
endmodule : can_receive_irq_enable_tb
